// ===== core/hps_pkg.sv
// Constants, encodings and carriers of the slot mode controller
package hps_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam int CTRL_ATTN_LSB = 0;
   localparam int CTRL_M66_LSB = 2;
   localparam int ST_SLOT_LSB = 0;
   localparam int ST_SLOT_W = 6;
   localparam int ST_MODE_LSB = 12;
   localparam int ST_FORCE_LSB = 15;
   localparam int ST_VALID_BIT = 17;
   // ==========================================================
   // Serial frame layout
   localparam int CMD_W = 4;
   localparam int FRAME_W = 8;
   localparam int CMD_PWR = 0;
   localparam int CMD_IOSEL = 1;
   localparam int CMD_ATTN = 2;
   // ==========================================================
   // Encodings
   typedef enum logic [2:0] {
      MODE_SINGLE = 3'b001,
      MODE_MULTI = 3'b010,
      MODE_DIRECT = 3'b100
   } hps_mode_e;
   typedef enum logic [2:0] {
      SLOT_OFF = 3'b001,
      SLOT_ON = 3'b010,
      SLOT_FAULT = 3'b100
   } hps_slot_e;
   // ==========================================================
   // Per-slot pin carriers
   typedef struct packed {
      logic mainFault;
      logic auxFault;
      logic slotSwitchInput;
      logic slotResetIn_n;
      logic slotPowerRequest;
      logic ioVoltageSelectIn;
      logic powerIndicatorPin_n;
      logic [2:0] capability;
      logic [3:0] voltageAbove;
   } hps_slot_in_s;
   typedef struct packed {
      logic mainPowerEnable;
      logic auxPowerEnable;
      logic slotFaultFlag;
      logic auxSupplyFaultFlag;
      logic slotPowerOffStatus;
      logic ioVoltageSelect;
      logic busConnectEnable;
      logic clockConnectEnable;
      logic slotResetOut_n;
      logic attentionIndicator;
      logic m66Out;
      logic m66Oe;
      logic [2:0] capabilityOut;
   } hps_slot_out_s;
   localparam int SLOT_IN_W = $bits(hps_slot_in_s);
endpackage

// ===== core/hps_mode_ctrl.sv
// Mode selection and slot control of a two-slot hot-plug power controller
// Function
// R1: Direct mode when high strap high, low strap low at supplies-valid rise.
// R2: Both straps low selects single-slot serial, one interface per slot.
// R3: Low strap high, high strap low selects one shared cascadable interface.
// R4: Low-side strap is weakly pulled low inside the device.
// R5: Device drives data on serial-in line, receives on serial-out line.
// R6: Direct mode runs each slot from its dedicated input pins.
// R7: Main-supply fault with main power on asserts slot fault flag.
// R8: Aux overcurrent with power on asserts aux fault and general fault.
// R9: Low power indicator at supplies-valid rise forces slot enable.
// R10: Forced slot powers aux and main while switch low; capability picks VIO.
// R11: Forced slot obeys only switch input; status still reported.
// R12: Forced slot powers down at once on any fault, no clock needed.
// R13: Forced main fault clears on power request low, aux on switch high.
// R14: Forced serial slot: bus and clock enable on, reset follows input.
// R15: Forced slot releases M66 pin and deasserts attention indicator.
// R16: Forced slot fault cuts power, drops bus/clock enable, asserts reset.
// R17: Power-off status only when all slot voltages are below threshold.
// R18: Bus/clock enables steer slot connection; reset output drives slot reset.
// R19: External source drives the needed strap high; single mode needs none.
// R20: Low power indicator selects force mode whatever the straps.
// R21: Forced slot ignores VIO select inputs, uses third capability bit.
// R22: Direct mode presents decoded capability on three bits per slot.
// R23: Mode latched once at supplies-valid rise, held until next power-up.
// R24: External source keeps straps stable around supplies-valid rise.
`timescale 1ns/1ps
module hps_mode_ctrl (
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic suppliesValid,
   input wire logic modeStrapLowSide,
   input wire logic modeStrapHighSide,
   output logic strapLowPullDownEn,
   input wire logic [1:0] controllerSerialOutLine,
   input wire logic [1:0] serialFrameStrobe,
   output logic [1:0] controllerSerialInLine,
   input wire hps_pkg::hps_slot_in_s [1:0] slotIn,
   output hps_pkg::hps_slot_out_s [1:0] slotOut,
   output hps_pkg::hps_mode_e opMode,
   output logic modeValid
);
   // ==========================================================
   // Input synchronisers
   localparam int AW = 7 + 2 * hps_pkg::SLOT_IN_W;
   logic [AW-1:0] asyncIn;
   logic [AW-1:0] syncA_r;
   logic [AW-1:0] syncB_r;
   logic pgoodS;
   logic strapLoS;
   logic strapHiS;
   logic [1:0] serOutS;
   logic [1:0] strobeS;
   hps_pkg::hps_slot_in_s [1:0] slotS;
   assign asyncIn = {suppliesValid, modeStrapLowSide, modeStrapHighSide,
                     controllerSerialOutLine, serialFrameStrobe, slotIn};
   always_ff @(posedge clk) begin
      if (!nrst) begin
         syncA_r <= '0;
         syncB_r <= '0;
      end else begin
         syncA_r <= asyncIn;
         syncB_r <= syncA_r;
      end
   end
   assign {pgoodS, strapLoS, strapHiS, serOutS, strobeS, slotS} = syncB_r;
   assign strapLowPullDownEn = 1'b1; // [R4]
   // ==========================================================
   // Mode latch
   logic pgoodD_r;
   logic pgoodRise;
   hps_pkg::hps_mode_e opMode_r;
   logic modeValid_r;
   logic [1:0] force_r;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pgoodD_r <= 1'b0;
      end else begin
         pgoodD_r <= pgoodS;
      end
   end
   assign pgoodRise = pgoodS & ~pgoodD_r;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         opMode_r <= hps_pkg::MODE_SINGLE;
         modeValid_r <= 1'b0;
         force_r <= 2'b00;
      end else if (pgoodRise) begin // [R23]
         modeValid_r <= 1'b1;
         force_r[0] <= ~slotS[0].powerIndicatorPin_n; // [R9] [R20]
         force_r[1] <= ~slotS[1].powerIndicatorPin_n; // [R9] [R20]
         case ({strapHiS, strapLoS})
            2'b10: opMode_r <= hps_pkg::MODE_DIRECT; // [R1]
            2'b01: opMode_r <= hps_pkg::MODE_MULTI; // [R3]
            default: opMode_r <= hps_pkg::MODE_SINGLE; // [R2]
         endcase
      end else if (!pgoodS) begin
         modeValid_r <= 1'b0;
      end
   end
   assign opMode = opMode_r;
   assign modeValid = modeValid_r;
   // ==========================================================
   // Serial interfaces
   logic [1:0][hps_pkg::FRAME_W-1:0] shiftIn_r;
   logic [1:0][hps_pkg::FRAME_W-1:0] shiftOut_r;
   logic [1:0][hps_pkg::FRAME_W-1:0] cmd_r;
   logic [1:0][hps_pkg::FRAME_W-1:0] statFrame;
   logic [1:0] strobeD_r;
   logic [1:0][hps_pkg::CMD_W-1:0] slotCmd;
   logic [1:0][hps_pkg::CMD_W-1:0] slotStat;
   logic isMulti;
   logic isDirect;
   assign isMulti = opMode_r == hps_pkg::MODE_MULTI;
   assign isDirect = opMode_r == hps_pkg::MODE_DIRECT;
   always_comb begin
      if (isMulti) begin // [R3]
         statFrame[0] = {slotStat[1], slotStat[0]};
         statFrame[1] = '0;
         slotCmd[0] = cmd_r[0][hps_pkg::CMD_W-1:0];
         slotCmd[1] = cmd_r[0][hps_pkg::FRAME_W-1:hps_pkg::CMD_W];
      end else begin // [R2]
         statFrame[0] = {4'h0, slotStat[0]};
         statFrame[1] = {4'h0, slotStat[1]};
         slotCmd[0] = cmd_r[0][hps_pkg::CMD_W-1:0];
         slotCmd[1] = cmd_r[1][hps_pkg::CMD_W-1:0];
      end
   end
   always_ff @(posedge clk) begin
      if (!nrst) begin
         shiftIn_r <= '0;
         shiftOut_r <= '0;
         cmd_r <= '0;
         strobeD_r <= 2'b00;
      end else begin
         strobeD_r <= strobeS;
         for (int i = 0; i < 2; i++) begin
            shiftIn_r[i] <= {shiftIn_r[i][hps_pkg::FRAME_W-2:0], serOutS[i]}; // [R5]
            if (strobeS[i] && !strobeD_r[i]) begin
               cmd_r[i] <= shiftIn_r[i];
               shiftOut_r[i] <= statFrame[i];
            end else begin
               shiftOut_r[i] <= {shiftOut_r[i][hps_pkg::FRAME_W-2:0], 1'b0};
            end
         end
      end
   end
   assign controllerSerialInLine[0] = shiftOut_r[0][hps_pkg::FRAME_W-1]; // [R5]
   assign controllerSerialInLine[1] = shiftOut_r[1][hps_pkg::FRAME_W-1]; // [R5]
   // ==========================================================
   // APB registers
   logic [3:0] ctrl_r;
   logic [31:0] statusWord;
   logic setup;
   logic mapped;
   hps_pkg::hps_slot_e [1:0] state_r;
   logic [1:0] mainFlt_r;
   logic [1:0] auxFlt_r;
   assign setup = psel & ~penable;
   assign mapped = paddr == hps_pkg::ADDR_CTRL || paddr == hps_pkg::ADDR_STATUS;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   always_comb begin
      statusWord = '0;
      for (int i = 0; i < 2; i++) begin
         statusWord[hps_pkg::ST_SLOT_LSB + i*hps_pkg::ST_SLOT_W +: hps_pkg::ST_SLOT_W] =
            {auxFlt_r[i], mainFlt_r[i], 1'b0, state_r[i]};
      end
      statusWord[hps_pkg::ST_MODE_LSB +: 3] = opMode_r;
      statusWord[hps_pkg::ST_FORCE_LSB +: 2] = force_r;
      statusWord[hps_pkg::ST_VALID_BIT] = modeValid_r;
   end
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ctrl_r <= hps_pkg::CTRL_RST;
      end else if (psel && penable && pwrite && paddr == hps_pkg::ADDR_CTRL) begin
         ctrl_r <= pwdata[3:0];
      end
   end
   always_ff @(posedge clk) begin
      if (!nrst) begin
         prdata <= '0;
      end else if (setup && !pwrite) begin
         case (paddr)
            hps_pkg::ADDR_CTRL: prdata <= {28'h0000000, ctrl_r};
            hps_pkg::ADDR_STATUS: prdata <= statusWord;
            default: prdata <= '0;
         endcase
      end
   end
   // ==========================================================
   // Slot control
   for (genvar s = 0; s < 2; s++) begin : gSlot
      logic req;
      logic clrMain;
      logic clrAux;
      logic isOn;
      logic busEn_r;
      logic rstOut_r;
      logic ioSel_r;
      logic attn_r;
      logic m66Oe_r;
      logic pwrOff_r;
      logic [2:0] cap_r;
      logic rawCut;
      hps_pkg::hps_slot_e nxt;
      always_comb begin
         if (force_r[s]) begin
            req = ~slotS[s].slotSwitchInput; // [R10] [R11]
            clrMain = ~slotS[s].slotPowerRequest; // [R13]
            clrAux = slotS[s].slotSwitchInput; // [R13]
         end else if (isDirect) begin
            req = slotS[s].slotPowerRequest; // [R6]
            clrMain = ~req;
            clrAux = ~req;
         end else begin
            req = slotCmd[s][hps_pkg::CMD_PWR];
            clrMain = ~req;
            clrAux = ~req;
         end
      end
      assign isOn = state_r[s] == hps_pkg::SLOT_ON;
      always_ff @(posedge clk) begin
         if (!nrst) begin
            mainFlt_r[s] <= 1'b0;
            auxFlt_r[s] <= 1'b0;
         end else begin
            mainFlt_r[s] <= (isOn & slotS[s].mainFault) | (mainFlt_r[s] & ~clrMain); // [R7]
            auxFlt_r[s] <= (isOn & slotS[s].auxFault) | (auxFlt_r[s] & ~clrAux); // [R8]
         end
      end
      always_comb begin
         case (state_r[s])
            hps_pkg::SLOT_OFF: nxt = (req && modeValid_r) ? hps_pkg::SLOT_ON : hps_pkg::SLOT_OFF;
            hps_pkg::SLOT_ON: begin
               if (slotS[s].mainFault || slotS[s].auxFault) begin
                  nxt = hps_pkg::SLOT_FAULT;
               end else if (!req || !modeValid_r) begin
                  nxt = hps_pkg::SLOT_OFF;
               end else begin
                  nxt = hps_pkg::SLOT_ON;
               end
            end
            hps_pkg::SLOT_FAULT: nxt = (mainFlt_r[s] || auxFlt_r[s]) ? hps_pkg::SLOT_FAULT : hps_pkg::SLOT_OFF;
            default: nxt = hps_pkg::SLOT_OFF;
         endcase
      end
      always_ff @(posedge clk) begin
         if (!nrst) begin
            state_r[s] <= hps_pkg::SLOT_OFF;
         end else begin
            state_r[s] <= nxt;
         end
      end
      always_ff @(posedge clk) begin
         if (!nrst) begin
            busEn_r <= 1'b0;
            rstOut_r <= 1'b0;
            ioSel_r <= 1'b0;
            attn_r <= 1'b0;
            m66Oe_r <= 1'b0;
            pwrOff_r <= 1'b1;
            cap_r <= 3'h0;
         end else begin
            busEn_r <= isOn; // [R14] [R16] [R18]
            rstOut_r <= isOn & (~force_r[s] | slotS[s].slotResetIn_n); // [R14] [R16]
            ioSel_r <= force_r[s] ? slotS[s].capability[2] : // [R21]
                       isDirect ? slotS[s].ioVoltageSelectIn : slotCmd[s][hps_pkg::CMD_IOSEL];
            attn_r <= ~force_r[s] & (slotCmd[s][hps_pkg::CMD_ATTN] | ctrl_r[hps_pkg::CTRL_ATTN_LSB + s]); // [R15]
            m66Oe_r <= ~force_r[s] & isOn & ctrl_r[hps_pkg::CTRL_M66_LSB + s]; // [R15]
            pwrOff_r <= ~|slotS[s].voltageAbove; // [R17]
            cap_r <= isDirect ? slotS[s].capability : 3'h0; // [R22]
         end
      end
      assign slotStat[s] = {pwrOff_r, auxFlt_r[s], mainFlt_r[s] | auxFlt_r[s], isOn}; // [R11]
      // Raw fault pins cut power of a forced slot without waiting for the synchroniser
      assign rawCut = force_r[s] & (slotIn[s].mainFault | slotIn[s].auxFault); // [R12]
      assign slotOut[s].mainPowerEnable = isOn & ~rawCut; // [R12]
      assign slotOut[s].auxPowerEnable = isOn & ~rawCut; // [R10] [R12]
      assign slotOut[s].slotFaultFlag = mainFlt_r[s] | auxFlt_r[s]; // [R7] [R8]
      assign slotOut[s].auxSupplyFaultFlag = auxFlt_r[s]; // [R8]
      assign slotOut[s].slotPowerOffStatus = pwrOff_r;
      assign slotOut[s].ioVoltageSelect = ioSel_r;
      assign slotOut[s].busConnectEnable = busEn_r;
      assign slotOut[s].clockConnectEnable = busEn_r;
      assign slotOut[s].slotResetOut_n = rstOut_r;
      assign slotOut[s].attentionIndicator = attn_r;
      assign slotOut[s].m66Out = 1'b0;
      assign slotOut[s].m66Oe = m66Oe_r;
      assign slotOut[s].capabilityOut = cap_r;
      // ==========================================================
      // Slot checks
      force_entry_a: assert property (@(posedge clk) disable iff (!nrst) // [R9]
         pgoodRise && !slotS[s].powerIndicatorPin_n |=> force_r[s])
         else $error("force mode not latched");
      main_fault_flag_a: assert property (@(posedge clk) disable iff (!nrst) // [R7]
         isOn && slotS[s].mainFault |=> slotOut[s].slotFaultFlag)
         else $error("main fault flag missing");
      aux_fault_flag_a: assert property (@(posedge clk) disable iff (!nrst) // [R8]
         isOn && slotS[s].auxFault |=> slotOut[s].auxSupplyFaultFlag && slotOut[s].slotFaultFlag)
         else $error("aux fault flags missing");
      force_power_cut_a: assert property (@(posedge clk) disable iff (!nrst) // [R12]
         force_r[s] && slotIn[s].mainFault |-> !slotOut[s].mainPowerEnable)
         else $error("forced slot still powered on fault");
      aux_clear_a: assert property (@(posedge clk) disable iff (!nrst) // [R13]
         force_r[s] && auxFlt_r[s] && !slotS[s].slotSwitchInput |=> auxFlt_r[s])
         else $error("aux fault cleared early");
      force_bus_off_a: assert property (@(posedge clk) disable iff (!nrst) // [R16]
         force_r[s] && state_r[s] == hps_pkg::SLOT_FAULT ##1 state_r[s] == hps_pkg::SLOT_FAULT
         |-> !slotOut[s].busConnectEnable && !slotOut[s].slotResetOut_n)
         else $error("bus not disconnected after fault");
      power_off_a: assert property (@(posedge clk) disable iff (!nrst) // [R17]
         |slotS[s].voltageAbove |=> !slotOut[s].slotPowerOffStatus)
         else $error("power off reported with voltage present");
      force_vio_a: assert property (@(posedge clk) disable iff (!nrst) // [R21]
         force_r[s] && $past(force_r[s]) |-> slotOut[s].ioVoltageSelect == $past(slotS[s].capability[2]))
         else $error("forced VIO not from capability");
      force_attn_a: assert property (@(posedge clk) disable iff (!nrst) // [R15]
         force_r[s] && $past(force_r[s]) |-> !slotOut[s].attentionIndicator && !slotOut[s].m66Oe)
         else $error("attention or M66 driven in force mode");
      force_aux_cut_a: assert property (@(posedge clk) disable iff (!nrst) // [R12]
         force_r[s] && (slotIn[s].mainFault || slotIn[s].auxFault) |-> !slotOut[s].auxPowerEnable)
         else $error("forced slot aux still powered on fault");
      main_clear_a: assert property (@(posedge clk) disable iff (!nrst) // [R13]
         force_r[s] && mainFlt_r[s] && slotS[s].slotPowerRequest |=> mainFlt_r[s])
         else $error("main fault cleared early");
      direct_cap_a: assert property (@(posedge clk) disable iff (!nrst) // [R22]
         isDirect && $past(isDirect) |-> slotOut[s].capabilityOut == $past(slotS[s].capability))
         else $error("direct capability not presented");
   end
   // ==========================================================
   // Mode checks
   direct_entry_a: assert property (@(posedge clk) disable iff (!nrst) // [R1]
      pgoodRise && strapHiS && !strapLoS |=> opMode_r == hps_pkg::MODE_DIRECT)
      else $error("direct mode not entered");
   single_entry_a: assert property (@(posedge clk) disable iff (!nrst) // [R2]
      pgoodRise && !strapHiS && !strapLoS |=> opMode_r == hps_pkg::MODE_SINGLE)
      else $error("single mode not entered");
   multi_entry_a: assert property (@(posedge clk) disable iff (!nrst) // [R3]
      pgoodRise && !strapHiS && strapLoS |=> opMode_r == hps_pkg::MODE_MULTI)
      else $error("multi mode not entered");
   mode_hold_a: assert property (@(posedge clk) disable iff (!nrst) // [R23]
      !pgoodRise |=> $stable(opMode_r) && $stable(force_r))
      else $error("mode changed without power-up");
endmodule

// ===== dv/hps_init_source.sv
// Power-up source and serial hot-plug controller model at the far side
`timescale 1ns/1ps
module hps_init_source (
   input wire logic clk,
   output logic suppliesValid,
   output logic modeStrapLowSide,
   output logic modeStrapHighSide,
   output logic [1:0] controllerSerialOutLine,
   output logic [1:0] serialFrameStrobe
);
   initial begin
      suppliesValid = 1'b0;
      modeStrapLowSide = 1'b0;
      modeStrapHighSide = 1'b0;
      controllerSerialOutLine = 2'b01;
      serialFrameStrobe = 2'b00;
   end
   // ==========================================================
   // Supplies dropped before a reset so no stale rise follows it
   task automatic power_down();
      suppliesValid <= 1'b0;
   endtask
   // Straps set, held around the supplies-valid rise, then moved
   task automatic power_up(input logic hi, input logic lo);
      suppliesValid <= 1'b0;
      repeat (4) @(posedge clk);
      modeStrapHighSide <= hi;
      modeStrapLowSide <= lo;
      repeat (4) @(posedge clk);
      suppliesValid <= 1'b1;
      repeat (5) @(posedge clk);
      modeStrapHighSide <= !hi;
      modeStrapLowSide <= !lo;
      repeat (2) @(posedge clk);
   endtask
   // ==========================================================
   // Command frame, MSB first, closed by the strobe
   task automatic send_frame(input int i, input logic [7:0] b);
      for (int k = 7; k >= 0; k--) begin
         controllerSerialOutLine[i] <= b[k];
         @(posedge clk);
      end
      serialFrameStrobe[i] <= 1'b1;
      repeat (3) @(posedge clk);
      serialFrameStrobe[i] <= 1'b0;
      controllerSerialOutLine[i] <= !b[0];
      repeat (2) @(posedge clk);
   endtask
endmodule

// ===== dv/hps_mode_ctrl_bench.sv
// Self-checking bench of the slot mode controller
`timescale 1ns/1ps
module hps_mode_ctrl_bench;
   typedef struct packed {
      logic [1:0] kind;
      logic idx;
      logic [32:0] exp;
      logic [32:0] msk;
   } hps_note_s;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, suppliesValid, modeStrapLowSide, modeStrapHighSide, strapLowPullDownEn, modeValid;
   logic [1:0] serOut, strobe, serIn;
   hps_pkg::hps_slot_in_s [1:0] slotIn;
   hps_pkg::hps_slot_out_s [1:0] slotOut;
   hps_pkg::hps_mode_e opMode;
   hps_pkg::hps_slot_out_s mBase, mDir, mForce, mPwr;
   hps_note_s q[$];
   logic [2:0] modeTab [4] = '{3'b001, 3'b010, 3'b100, 3'b001};
   logic [31:0] rnd;
   int n_mismatch = 0;
   int comparisons = 0;
   always #10 clk = ~clk;
   hps_mode_ctrl dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .suppliesValid(suppliesValid),
      .modeStrapLowSide(modeStrapLowSide), .modeStrapHighSide(modeStrapHighSide),
      .strapLowPullDownEn(strapLowPullDownEn), .controllerSerialOutLine(serOut), .serialFrameStrobe(strobe),
      .controllerSerialInLine(serIn), .slotIn(slotIn), .slotOut(slotOut), .opMode(opMode), .modeValid(modeValid));
   hps_init_source src (.clk(clk), .suppliesValid(suppliesValid), .modeStrapLowSide(modeStrapLowSide),
      .modeStrapHighSide(modeStrapHighSide), .controllerSerialOutLine(serOut), .serialFrameStrobe(strobe));
   // ==========================================================
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic hps_pkg::hps_slot_out_s mk(input logic pm, pa, f, af, off, bus, rst, att, oe, vio,
         input logic [2:0] cap);
      mk = '0;
      mk.mainPowerEnable = pm;
      mk.auxPowerEnable = pa;
      mk.slotFaultFlag = f;
      mk.auxSupplyFaultFlag = af;
      mk.slotPowerOffStatus = off;
      mk.busConnectEnable = bus;
      mk.clockConnectEnable = bus;
      mk.slotResetOut_n = rst;
      mk.attentionIndicator = att;
      mk.m66Oe = oe;
      mk.ioVoltageSelect = vio;
      mk.capabilityOut = cap;
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic note(input logic [1:0] k, input logic s, input logic [32:0] e, input logic [32:0] m);
      #1 q.push_back('{k, s, e, m});
      @(posedge clk);
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e,
         input logic [32:0] m);
      int n;
      if (!wr)
         q.push_back('{2'd0, 1'b0, e, m});
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50)
         n_mismatch++;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic start(input logic hi, input logic lo, input logic [1:0] pin);
      nrst <= 1'b0;
      src.power_down();
      for (int s = 0; s < 2; s++) begin
         slotIn[s] <= '0;
         slotIn[s].slotResetIn_n <= 1'b1;
         slotIn[s].powerIndicatorPin_n <= pin[s];
      end
      cyc(4);
      nrst <= 1'b1;
      @(posedge clk);
      src.power_up(hi, lo);
   endtask
   // ==========================================================
   // Compare
   task automatic cmp(input logic [32:0] act, input hps_note_s n, input string what);
      comparisons++;
      if ((act & n.msk) !== (n.exp & n.msk)) begin
         n_mismatch++;
         $display("FAIL %0t %s %0d got %h want %h", $time, what, n.idx, act & n.msk, n.exp & n.msk);
      end
   endtask
   task automatic cmp_apb(input hps_note_s n);
      cmp({pslverr, prdata}, n, "apb read");
   endtask
   task automatic cmp_mode(input hps_note_s n);
      cmp({26'h0, strapLowPullDownEn, serIn, modeValid, opMode}, n, "mode");
   endtask
   task automatic cmp_slot(input hps_note_s n);
      cmp({18'h0, slotOut[n.idx]}, n, "slot");
   endtask
   always @(posedge clk) begin
      if (q.size() > 0 && q[0].kind == 2'd0 && psel && penable && pready === 1'b1 && !pwrite)
         cmp_apb(q.pop_front());
      else if (q.size() > 0 && q[0].kind == 2'd1)
         cmp_mode(q.pop_front());
      else if (q.size() > 0 && q[0].kind == 2'd2)
         cmp_slot(q.pop_front());
   end
   task automatic wrap_up();
      if (q.size() > 0)
         n_mismatch++;
      if (n_mismatch == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      wrap_up();
   end
   // ==========================================================
   // Scenarios
   initial begin
      rnd = 32'ha5d2931d;
      mBase = mk(1, 1, 1, 1, 1, 1, 1, 0, 0, 0, 3'h0);
      mDir = mk(1, 1, 1, 1, 1, 1, 1, 0, 0, 0, 3'h7);
      mForce = mk(1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 3'h0);
      mPwr = mk(1, 1, 0, 0, 0, 0, 0, 0, 0, 0, 3'h0);
      for (int s = 0; s < 2; s++) begin
         slotIn[s] = '0;
         slotIn[s].slotResetIn_n = 1'b1;
         slotIn[s].powerIndicatorPin_n = 1'b1;
      end
      cyc(2);
      note(2'd1, 1'b0, {26'h0, 1'b1, 2'b00, 1'b0, 3'b001}, '1);
      note(2'd2, 1'b0, mk(0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 3'h0), '1);
      nrst <= 1'b1;
      @(posedge clk);
      apb(1'b0, hps_pkg::ADDR_CTRL, 32'h0, {5'h0, 24'h0, hps_pkg::CTRL_RST}, '1);
      for (int k = 0; k < 4; k++) begin
         rnd = lfsr(rnd);
         apb(1'b1, hps_pkg::ADDR_CTRL, rnd, '0, '0);
         apb(1'b0, hps_pkg::ADDR_CTRL, 32'h0, {29'h0, rnd[3:0]}, '1);
      end
      apb(1'b1, 8'h08, 32'hffffffff, '0, '0);
      apb(1'b0, 8'h08, 32'h0, {1'b1, 32'h0}, '1);
      apb(1'b0, hps_pkg::ADDR_CTRL, 32'h0, {29'h0, rnd[3:0]}, '1);
      for (int k = 0; k < 4; k++) begin
         start(k[1], k[0], 2'b11);
         note(2'd1, 1'b0, {26'h0, 1'b1, 2'b00, 1'b1, modeTab[k]}, '1);
      end
      start(1'b1, 1'b0, 2'b01);
      slotIn[0].capability <= 3'b101;
      slotIn[0].slotPowerRequest <= 1'b1;
      slotIn[0].voltageAbove <= 4'hf;
      slotIn[1].slotSwitchInput <= 1'b1;
      slotIn[1].slotPowerRequest <= 1'b1;
      cyc(6);
      note(2'd2, 1'b0, mk(1, 1, 0, 0, 0, 1, 1, 0, 0, 0, 3'b101), mDir);
      note(2'd2, 1'b1, mk(0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 3'h0), mBase);
      slotIn[0].mainFault <= 1'b1;
      cyc(6);
      note(2'd2, 1'b0, mk(0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 3'h0), mBase);
      slotIn[0].mainFault <= 1'b0;
      slotIn[0].slotPowerRequest <= 1'b0;
      slotIn[0].voltageAbove <= 4'b0100;
      cyc(6);
      note(2'd2, 1'b0, mk(0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 3'h0), mBase);
      slotIn[0].voltageAbove <= 4'h0;
      slotIn[0].slotPowerRequest <= 1'b1;
      cyc(6);
      slotIn[0].auxFault <= 1'b1;
      cyc(6);
      note(2'd2, 1'b0, mk(0, 0, 1, 1, 1, 0, 0, 0, 0, 0, 3'h0), mBase);
      apb(1'b1, hps_pkg::ADDR_CTRL, 32'hf, '0, '0);
      slotIn[1].slotSwitchInput <= 1'b0;
      slotIn[1].capability <= 3'b100;
      slotIn[1].voltageAbove <= 4'hf;
      cyc(6);
      note(2'd2, 1'b1, mk(1, 1, 0, 0, 0, 1, 1, 0, 0, 1, 3'h0), mForce);
      slotIn[1].slotResetIn_n <= 1'b0;
      cyc(6);
      note(2'd2, 1'b1, mk(1, 1, 0, 0, 0, 1, 0, 0, 0, 1, 3'h0), mForce);
      slotIn[1].slotResetIn_n <= 1'b1;
      apb(1'b0, hps_pkg::ADDR_STATUS, 32'h0, {15'h0, 6'h34, 12'h0}, {15'h0, 6'h3f, 12'h0});
      slotIn[1].mainFault <= 1'b1;
      note(2'd2, 1'b1, mk(0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 3'h0), mPwr);
      cyc(5);
      note(2'd2, 1'b1, mk(0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 3'h0), mBase);
      slotIn[1].mainFault <= 1'b0;
      cyc(6);
      note(2'd2, 1'b1, mk(0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 3'h0), mBase);
      slotIn[1].slotPowerRequest <= 1'b0;
      cyc(6);
      note(2'd2, 1'b1, mk(1, 1, 0, 0, 0, 1, 1, 0, 0, 0, 3'h0), mBase);
      slotIn[1].slotSwitchInput <= 1'b1;
      cyc(6);
      slotIn[1].slotSwitchInput <= 1'b0;
      cyc(6);
      slotIn[1].auxFault <= 1'b1;
      cyc(6);
      slotIn[1].auxFault <= 1'b0;
      cyc(6);
      note(2'd2, 1'b1, mk(0, 0, 1, 1, 0, 0, 0, 0, 0, 0, 3'h0), mBase);
      slotIn[1].slotSwitchInput <= 1'b1;
      cyc(6);
      note(2'd2, 1'b1, mk(0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 3'h0), mBase);
      start(1'b0, 1'b0, 2'b11);
      src.send_frame(0, 8'h01);
      cyc(2);
      note(2'd1, 1'b0, {26'h0, 1'b1, 2'b01, 1'b1, 3'b001}, '1);
      cyc(8);
      note(2'd2, 1'b0, mk(1, 1, 0, 0, 1, 1, 1, 0, 0, 0, 3'h0), mBase);
      note(2'd2, 1'b1, mk(0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 3'h0), mBase);
      start(1'b0, 1'b1, 2'b11);
      src.send_frame(0, 8'h10);
      cyc(8);
      note(2'd2, 1'b1, mk(1, 1, 0, 0, 1, 1, 1, 0, 0, 0, 3'h0), mBase);
      note(2'd2, 1'b0, mk(0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 3'h0), mBase);
      cyc(2);
      wrap_up();
   end
endmodule
